// ---- verilog/tbl_access_pkg.sv ----
/*
 * Constants for the VLAN membership table and the ToS/CS priority table.
 * Assumes one core clock and one reset shared with the switch engine.
 */
package tbl_access_pkg;
   // register indices; the byte address is four times the index
   localparam logic [13:0] IDX_VLAN_STATUS   = 14'h1810;
   localparam logic [13:0] IDX_PRIO_COMMAND  = 14'h1811;
   localparam logic [13:0] IDX_PRIO_WDATA    = 14'h1812;
   localparam logic [13:0] IDX_PRIO_RDATA    = 14'h1813;
   localparam logic [13:0] IDX_PRIO_STATUS   = 14'h1814;
   localparam logic [13:0] IDX_VLAN_COMMAND  = 14'h1820;
   localparam logic [13:0] IDX_VLAN_WDATA    = 14'h1821;
   localparam logic [13:0] IDX_VLAN_RDATA    = 14'h1822;
   localparam logic [13:0] IDX_ADMIT_NONMEM  = 14'h1823;
   localparam logic [13:0] IDX_EGRESS_KIND   = 14'h1824;
   localparam logic [13:0] IDX_IRQ_STATUS    = 14'h1825;
   localparam logic [13:0] IDX_IRQ_MASK      = 14'h1826;

   // VLAN entry fields
   localparam int VLAN_ENTRY_W  = 18;
   localparam int VID_W         = 12;
   localparam int VID_LSB       = 0;
   localparam int UNTAG_P0_BIT  = 12;
   localparam int MEMBER_P0_BIT = 13;
   localparam int PORT_STRIDE   = 2;
   localparam int NUM_PORTS     = 3;
   localparam logic [VID_W-1:0] NULL_VID = 12'h000;

   // command register fields, shared by both tables
   localparam int CMD_DIR_BIT = 7;
   localparam int CMD_IDX_LSB = 0;
   localparam int PRIO_IDX_W  = 6;
   localparam int VLAN_IDX_W  = 4;
   localparam int PRIO_W      = 3;
   localparam int PEND_BIT    = 0;

   // interrupt status bits
   localparam int IRQ_PRIO_DONE = 0;
   localparam int IRQ_VLAN_DONE = 1;
   localparam int IRQ_W         = 2;

   localparam logic [3:0] ACCESS_CYCLES = 4'h2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [2:0] {
      ACC_IDLE = 3'b001,
      ACC_RUN  = 3'b010,
      ACC_DONE = 3'b100
   } access_state_t;
endpackage : tbl_access_pkg

// ---- verilog/vlan_priority_table_access.sv ----
/*
 * AHB-Lite register slave with the VLAN membership table, the 64-entry
 * ToS/CS priority table, and the lookups the forwarding logic uses.
 * Assumes lookup requests come from logic on clk_sys, so they are not
 * synchronised; a single master with whole-word single transfers.
 */
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - vlan entry: member and untag bit per port at 17..12, reset zero
// - member port accepts vlan packets and joins its broadcast domain
// - nonmember drops ingress unless admit-nonmember set; excluded from domain
// - untag bit on a hybrid egress port strips the vlan tag
// - bits 11:0 hold the vid, reset zero; zero means disabled entry
// - vlan pending flag bit 0 high during access, self-clears, resets zero
// - a write to the priority command register while idle launches one access
// - command bit 7: one reads, zero writes; resets zero
// - command bits 5:0 index, reset zero; bit 6 and 31:8 read zero
// - priority table contents are not initialised by reset
// - write-data bits 2:0 priority, reset zero, stored on write command
// - received tos/cs code indexes the table to give its priority
// - priority pending flag bit 0 high during access, self-clears
// - after a read, read-data bits 2:0 show the indexed priority
module vlan_priority_table_access #(
   parameter int VLAN_ENTRIES = 16,
   parameter int PRIO_ENTRIES = 64
) (
   input  wire logic                             clk_sys,
   input  wire logic                             reset,
   input  wire logic                             hsel,
   input  wire logic [31:0]                      haddr,
   input  wire logic [1:0]                       htrans,
   input  wire logic                             hwrite,
   input  wire logic [2:0]                       hsize,
   input  wire logic [31:0]                      hwdata,
   input  wire logic                             hready,
   output logic      [31:0]                      hrdata,
   output logic                                  hreadyout,
   output logic                                  hresp,
   output logic                                  irq,
   input  wire logic                             vlanLookupValid,
   input  wire logic [tbl_access_pkg::VID_W-1:0] vlanLookupVid,
   input  wire logic [1:0]                       ingressPort,
   output logic                                  vlanAccept,
   output logic      [2:0]                       vlanEgressMembers,
   output logic      [2:0]                       vlanStripTag,
   input  wire logic [5:0]                       tosCode,
   output logic      [tbl_access_pkg::PRIO_W-1:0] ipPriority
);
   import tbl_access_pkg::*;

   // bus data phase
   logic              dWrite;
   logic              dRead;
   logic [13:0]       dIndex;
   wire               addrTaken = hsel & hready & htrans[1];
   wire               wrEn      = dWrite;

   // software registers
   logic [PRIO_IDX_W-1:0] prioIndex;
   logic                  prioDirection;
   logic [PRIO_W-1:0]     prioWriteData;
   logic [PRIO_W-1:0]     prioReadData;
   logic [VLAN_IDX_W-1:0] vlanIndex;
   logic                  vlanDirection;
   logic [VLAN_ENTRY_W-1:0] vlanWriteData;
   logic [VLAN_ENTRY_W-1:0] vlanReadData;
   logic [NUM_PORTS-1:0]  admitNonmember;
   logic [NUM_PORTS-1:0]  egressHybrid;
   logic [IRQ_W-1:0]      irqStatus;
   logic [IRQ_W-1:0]      irqMask;

   // tables
   logic [PRIO_W-1:0]       prioTable [PRIO_ENTRIES];
   logic [VLAN_ENTRY_W-1:0] vlanTable [VLAN_ENTRIES];

   access_state_t prioState;
   access_state_t vlanState;
   access_state_t next_prioState;
   access_state_t next_vlanState;
   logic [3:0]    prioCount;
   logic [3:0]    vlanCount;

   function automatic logic [31:0] zext(input logic [VLAN_ENTRY_W-1:0] v);
      zext = {{(32-VLAN_ENTRY_W){1'b0}}, v};
   endfunction : zext

   function automatic logic [3:0] next_count(input access_state_t s, input logic [3:0] c);
      next_count = (s == ACC_RUN) ? c + 4'h1 : 4'h0;
   endfunction : next_count

   // write decode
   wire wrPrioCmd   = wrEn && dIndex == IDX_PRIO_COMMAND;
   wire wrPrioData  = wrEn && dIndex == IDX_PRIO_WDATA;
   wire wrVlanCmd   = wrEn && dIndex == IDX_VLAN_COMMAND;
   wire wrVlanData  = wrEn && dIndex == IDX_VLAN_WDATA;
   wire wrAdmit     = wrEn && dIndex == IDX_ADMIT_NONMEM;
   wire wrEgress    = wrEn && dIndex == IDX_EGRESS_KIND;
   wire wrIrqStatus = wrEn && dIndex == IDX_IRQ_STATUS;
   wire wrIrqMask   = wrEn && dIndex == IDX_IRQ_MASK;

   wire vlanPending = vlanState != ACC_IDLE;
   wire prioPending = prioState != ACC_IDLE;
   wire prioDone    = prioState == ACC_DONE;
   wire vlanDone    = vlanState == ACC_DONE;

   // read mux; reserved bits read zero
   wire [31:0] readMux =
      (dIndex == IDX_VLAN_STATUS)  ? {31'h0, vlanPending} :
      (dIndex == IDX_PRIO_COMMAND) ? {24'h0, prioDirection, 1'b0, prioIndex} :
      (dIndex == IDX_PRIO_WDATA)   ? {29'h0, prioWriteData} :
      (dIndex == IDX_PRIO_RDATA)   ? {29'h0, prioReadData} :
      (dIndex == IDX_PRIO_STATUS)  ? {31'h0, prioPending} :
      (dIndex == IDX_VLAN_COMMAND) ? {24'h0, vlanDirection, 3'h0, vlanIndex} :
      (dIndex == IDX_VLAN_WDATA)   ? zext(vlanWriteData) :
      (dIndex == IDX_VLAN_RDATA)   ? zext(vlanReadData) :
      (dIndex == IDX_ADMIT_NONMEM) ? {29'h0, admitNonmember} :
      (dIndex == IDX_EGRESS_KIND)  ? {29'h0, egressHybrid} :
      (dIndex == IDX_IRQ_STATUS)   ? {30'h0, irqStatus} :
      (dIndex == IDX_IRQ_MASK)     ? {30'h0, irqMask} : 32'h0;

   // bus phases: writes finish with no wait, reads take one wait state so
   // that a write in the preceding data phase is already visible
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dWrite    <= 1'b0;
         dRead     <= 1'b0;
         dIndex    <= 14'h0;
         hreadyout <= 1'b1;
         hrdata    <= 32'h0;
         hresp     <= 1'b0;
      end else begin
         dWrite <= addrTaken & hwrite;
         dRead  <= addrTaken & ~hwrite;
         if (addrTaken) begin
            dIndex <= haddr[15:2];
         end
         hreadyout <= ~(addrTaken & ~hwrite);
         if (dRead) begin
            hrdata <= readMux;
         end
      end
   end

   // command and data registers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prioIndex      <= '0;
         prioDirection  <= 1'b0;
         prioWriteData  <= '0;
         vlanIndex      <= '0;
         vlanDirection  <= 1'b0;
         vlanWriteData  <= '0;
         admitNonmember <= '0;
         egressHybrid   <= '0;
         irqMask        <= '0;
      end else begin
         if (wrPrioCmd) begin
            prioDirection <= hwdata[CMD_DIR_BIT];
            prioIndex     <= hwdata[CMD_IDX_LSB +: PRIO_IDX_W];
         end
         if (wrPrioData) begin
            prioWriteData <= hwdata[PRIO_W-1:0];
         end
         if (wrVlanCmd) begin
            vlanDirection <= hwdata[CMD_DIR_BIT];
            vlanIndex     <= hwdata[CMD_IDX_LSB +: VLAN_IDX_W];
         end
         if (wrVlanData) begin
            vlanWriteData <= hwdata[VLAN_ENTRY_W-1:0];
         end
         if (wrAdmit) begin
            admitNonmember <= hwdata[NUM_PORTS-1:0];
         end
         if (wrEgress) begin
            egressHybrid <= hwdata[NUM_PORTS-1:0];
         end
         if (wrIrqMask) begin
            irqMask <= hwdata[IRQ_W-1:0];
         end
      end
   end

   // a command write launches one access; later writes while busy launch nothing but still update index and direction
   always_comb begin
      next_prioState = prioState;
      case (prioState)
         ACC_IDLE: if (wrPrioCmd) next_prioState = ACC_RUN;
         ACC_RUN:  if (prioCount == ACCESS_CYCLES - 4'h1) next_prioState = ACC_DONE;
         ACC_DONE: next_prioState = ACC_IDLE;
         default:  next_prioState = ACC_IDLE;
      endcase
   end

   always_comb begin
      next_vlanState = vlanState;
      case (vlanState)
         ACC_IDLE: if (wrVlanCmd) next_vlanState = ACC_RUN;
         ACC_RUN:  if (vlanCount == ACCESS_CYCLES - 4'h1) next_vlanState = ACC_DONE;
         ACC_DONE: next_vlanState = ACC_IDLE;
         default:  next_vlanState = ACC_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prioState    <= ACC_IDLE;
         vlanState    <= ACC_IDLE;
         prioCount    <= 4'h0;
         vlanCount    <= 4'h0;
         prioReadData <= '0;
         vlanReadData <= '0;
      end else begin
         prioState <= next_prioState;
         vlanState <= next_vlanState;
         prioCount <= next_count(prioState, prioCount);
         vlanCount <= next_count(vlanState, vlanCount);
         if (prioDone && prioDirection) begin
            prioReadData <= prioTable[prioIndex];
         end
         if (vlanDone && vlanDirection) begin
            vlanReadData <= vlanTable[vlanIndex];
         end
      end
   end

   // no reset here: entries stay undefined until software writes them
   always_ff @(posedge clk_sys) begin
      if (prioDone && !prioDirection) begin
         prioTable[prioIndex] <= prioWriteData;
      end
   end

   // vlan entries clear to zero; vid zero disables the entry
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < VLAN_ENTRIES; i++) begin
            vlanTable[i] <= '0;
         end
      end else if (vlanDone && !vlanDirection) begin
         vlanTable[vlanIndex] <= vlanWriteData;
      end
   end

   // vlan match: the lowest matching non-null entry wins
   logic                    vlanHit;
   logic [VLAN_ENTRY_W-1:0] hitEntry;
   always_comb begin
      vlanHit  = 1'b0;
      hitEntry = '0;
      for (int i = VLAN_ENTRIES - 1; i >= 0; i--) begin
         if (vlanTable[i][VID_LSB +: VID_W] == vlanLookupVid && vlanLookupVid != NULL_VID) begin
            vlanHit  = 1'b1;
            hitEntry = vlanTable[i];
         end
      end
   end

   logic [NUM_PORTS-1:0] members;
   logic [NUM_PORTS-1:0] untags;
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         members[p] = vlanHit & hitEntry[MEMBER_P0_BIT + PORT_STRIDE*p];
         untags[p]  = vlanHit & hitEntry[UNTAG_P0_BIT + PORT_STRIDE*p];
      end
   end

   // ingress accept: member, or admit-nonmember for that port
   // port code 3 names no port, so it must not index past the bit vectors
   wire acceptNow = (ingressPort < NUM_PORTS) && (members[ingressPort] | admitNonmember[ingressPort]);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         vlanAccept        <= 1'b0;
         vlanEgressMembers <= '0;
         vlanStripTag      <= '0;
         ipPriority        <= '0;
      end else begin
         vlanAccept        <= vlanLookupValid & acceptNow;
         // broadcast domain from member bits only
         vlanEgressMembers <= members;
         // strip only on hybrid egress ports
         vlanStripTag      <= untags & egressHybrid;
         // tos/cs code indexes the priority table
         ipPriority        <= prioTable[tosCode];
      end
   end

   // sticky completion events; a new event beats a same-cycle clear
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irqStatus <= '0;
         irq       <= 1'b0;
      end else begin
         irqStatus <= (irqStatus & ~(wrIrqStatus ? hwdata[IRQ_W-1:0] : '0)) | {vlanDone, prioDone};
         irq       <= |(irqStatus & irqMask);
      end
   end
endmodule : vlan_priority_table_access

// ---- bench/vlan_priority_table_access_sva.sv ----
/*
 * Checker for the table access block: bus timing, reserved bits, lookups.
 * Assumes a single AHB-Lite master with hready tied to hreadyout.
 */
`timescale 1ns/1ps
module vlan_table_sva
   import tbl_access_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        irq,
   input wire logic        vlanLookupValid,
   input wire logic        vlanAccept
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire        rdReq  = hsel && hready && htrans[1] && !hwrite;
   wire        wrReq  = hsel && hready && htrans[1] && hwrite;
   wire [13:0] regIdx = haddr[15:2];

   okay_resp_a: assert property (hresp == 1'b0)
      else $error("response not okay");
   read_wait_a: assert property (rdReq |=> !hreadyout ##1 hreadyout)
      else $error("read wait not one cycle");
   write_nowait_a: assert property (wrReq |=> hreadyout)
      else $error("write stalled");
   cmd_reserved_a: assert property (rdReq && regIdx == IDX_PRIO_COMMAND |=> ##1
      hrdata[31:8] == 24'h0 && !hrdata[6]) else $error("command reserved bits set");
   prio_data_a: assert property (rdReq && (regIdx == IDX_PRIO_WDATA || regIdx == IDX_PRIO_RDATA)
      |=> ##1 hrdata[31:3] == 29'h0) else $error("priority data reserved bits set");
   vlan_status_a: assert property (rdReq && regIdx == IDX_VLAN_STATUS |=> ##1 hrdata[31:1] == 31'h0)
      else $error("vlan status reserved bits set");
   prio_status_a: assert property (rdReq && regIdx == IDX_PRIO_STATUS |=> ##1 hrdata[31:1] == 31'h0)
      else $error("priority status reserved bits set");
   unmapped_zero_a: assert property (rdReq && regIdx == 14'h1830 |=> ##1 hrdata == 32'h0)
      else $error("unmapped read not zero");
   accept_valid_a: assert property (vlanAccept |-> $past(vlanLookupValid))
      else $error("accept without lookup");

   read_wait_c: cover property (rdReq ##1 !hreadyout);
   accept_c: cover property (vlanAccept);
   irq_c: cover property ($rose(irq));
endmodule : vlan_table_sva

bind vlan_priority_table_access vlan_table_sva chk (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hrdata, .hreadyout, .hresp, .irq, .vlanLookupValid, .vlanAccept);

// ---- bench/vlan_priority_table_access_bench.sv ----
/*
 * Directed bench for the table access block over AHB-Lite.
 * Assumes hready is fed back from hreadyout; word transfers only.
 */
`timescale 1ns/1ps
module vlan_priority_table_access_bench;
   import tbl_access_pkg::*;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        vlanLookupValid = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [1:0]  ingressPort = 2'h0;
   logic [5:0]  tosCode = 6'h00;
   logic [11:0] vlanLookupVid = 12'h000;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, irq, vlanAccept;
   wire  [2:0]  vlanEgressMembers, vlanStripTag, ipPriority;
   int          err_count = 0;
   int          checks_done = 0;

   vlan_priority_table_access dut (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .vlanLookupValid, .vlanLookupVid, .ingressPort,
      .vlanAccept, .vlanEgressMembers, .vlanStripTag, .tosCode, .ipPriority);

   always #12.5 clk_sys = ~clk_sys;

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {16'h0000, idx, 2'b00};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   // launch a table access and poll its pending flag, bounded
   task automatic cmd(input logic [13:0] c, input logic [13:0] s, input logic [31:0] d);
      int n;
      n = 0;
      bus(1'b1, c, d);
      bus(1'b0, s, 32'h0);
      chk("pending set", rd[0], 1'b1);
      while (rd[0] !== 1'b0 && n < 4) begin
         bus(1'b0, s, 32'h0);
         n++;
      end
      chk("pending clear", rd[0], 1'b0);
   endtask : cmd

   task automatic lk(input logic [11:0] v, input logic [1:0] p, input logic [6:0] e);
      @(posedge clk_sys);
      vlanLookupValid <= 1'b1;
      vlanLookupVid <= v;
      ingressPort <= p;
      @(posedge clk_sys);
      @(posedge clk_sys);
      chk("lookup", {vlanAccept, vlanEgressMembers, vlanStripTag}, e);
      vlanLookupValid <= 1'b0;
   endtask : lk

   task automatic irq_is(input logic e);
      @(posedge clk_sys);
      @(posedge clk_sys);
      chk("irq", irq, e);
   endtask : irq_is

   task automatic t_reset;
      logic [13:0] regs [6] = '{IDX_VLAN_STATUS, IDX_PRIO_COMMAND, IDX_PRIO_WDATA, IDX_PRIO_STATUS, 14'h1830,
                                IDX_PRIO_RDATA};
      foreach (regs[i]) begin
         bus(1'b0, regs[i], 32'h0);
         chk("reset value", rd, 32'h0);
      end
      $display("test reset done");
   endtask : t_reset

   task automatic t_prio;
      logic [5:0] ix [3] = '{6'h00, 6'h25, 6'h3f};
      logic [2:0] p;
      // every entry first, so no lookup ever sees an unwritten entry
      for (int k = 0; k < 64; k++) begin
         bus(1'b1, IDX_PRIO_WDATA, {29'h0, k[2:0]});
         cmd(IDX_PRIO_COMMAND, IDX_PRIO_STATUS, {24'h0, 2'b00, k[5:0]});
      end
      @(posedge clk_sys);
      tosCode <= 6'h11;
      @(posedge clk_sys);
      @(posedge clk_sys);
      chk("ip priority all", ipPriority, 32'h1);
      foreach (ix[i]) begin
         p = ix[i][2:0] ^ 3'h5;
         bus(1'b1, IDX_PRIO_WDATA, {29'h1fffffff, p});
         bus(1'b0, IDX_PRIO_WDATA, 32'h0);
         chk("write data", rd, {29'h0, p});
         cmd(IDX_PRIO_COMMAND, IDX_PRIO_STATUS, {24'hffffff, 2'b01, ix[i]});
         cmd(IDX_PRIO_COMMAND, IDX_PRIO_STATUS, {24'h0, 2'b10, ix[i]});
         bus(1'b0, IDX_PRIO_COMMAND, 32'h0);
         chk("command", rd, {24'h0, 2'b10, ix[i]});
         bus(1'b0, IDX_PRIO_RDATA, 32'h0);
         chk("read data", rd, {29'h0, p});
         @(posedge clk_sys);
         tosCode <= ix[i];
         @(posedge clk_sys);
         @(posedge clk_sys);
         chk("ip priority", ipPriority, p);
      end
      $display("test priority done");
   endtask : t_prio

   task automatic t_vlan;
      bus(1'b1, IDX_VLAN_WDATA, 32'h00036123);
      cmd(IDX_VLAN_COMMAND, IDX_VLAN_STATUS, 32'h00000004);
      cmd(IDX_VLAN_COMMAND, IDX_VLAN_STATUS, 32'h00000084);
      bus(1'b0, IDX_VLAN_RDATA, 32'h0);
      chk("vlan entry", rd, 32'h00036123);
      bus(1'b1, IDX_EGRESS_KIND, 32'h6);
      lk(12'h123, 2'd1, 7'b0101110);
      lk(12'h123, 2'd0, 7'b1101110);
      lk(12'h000, 2'd0, 7'b0000000);
      bus(1'b1, IDX_ADMIT_NONMEM, 32'h2);
      lk(12'h124, 2'd1, 7'b1000000);
      $display("test vlan done");
   endtask : t_vlan

   task automatic t_irq;
      bus(1'b0, IDX_IRQ_STATUS, 32'h0);
      chk("irq status", rd, 32'h3);
      irq_is(1'b0);
      bus(1'b1, IDX_IRQ_MASK, 32'h3);
      irq_is(1'b1);
      bus(1'b1, IDX_IRQ_STATUS, 32'h1);
      irq_is(1'b1);
      bus(1'b1, IDX_IRQ_MASK, 32'h1);
      irq_is(1'b0);
      bus(1'b1, IDX_IRQ_STATUS, 32'h2);
      bus(1'b0, IDX_IRQ_STATUS, 32'h0);
      chk("irq cleared", rd, 32'h0);
      $display("test irq done");
   endtask : t_irq

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset();
      t_prio();
      t_vlan();
      t_irq();
      finish_test();
   end

   // far beyond the thousand-odd cycles the tests need
   initial begin
      #500000;
      err_count++;
      finish_test();
   end
endmodule : vlan_priority_table_access_bench
